// ===== rtl/term_decoder_regs.svh
`ifndef TERM_DECODER_REGS_SVH
`define TERM_DECODER_REGS_SVH

// structural defaults
`define TERM_COUNT         8
`define FUNC_CODE_W        6
`define FREQ_W             16
`define SPEED_BITS         7
`define STEP_W             3

// input function selector codes
`define FUNC_JOG           6'h06
`define FUNC_TWO_STEP      6'h09
`define FUNC_TRIP_CLEAR    6'h12
`define FUNC_3W_START      6'h14
`define FUNC_3W_STOP       6'h15
`define FUNC_3W_DIR        6'h16
`define FUNC_SPEED_FIRST   6'h20
`define FUNC_SPEED_LAST    6'h26

// frequency source for step zero
`define FSRC_ANALOG        2'h1
`define FSRC_PANEL         2'h2

// run command source
`define RSRC_TERMINAL      2'h1

// jog stop selection
`define JSTOP_FREE_OFF     3'h0
`define JSTOP_DECEL_OFF    3'h1
`define JSTOP_DC_OFF       3'h2
`define JSTOP_FREE_ON      3'h3
`define JSTOP_DECEL_ON     3'h4
`define JSTOP_DC_ON        3'h5

// jog frequency in units of 0.01 Hz
`define JOG_FREQ_MAX       16'h03E7
`define JOG_FREQ_DEFAULT   16'h0258

`endif

// ===== rtl/term_decoder_pkg.sv
package term_decoder_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_JOG,
        ST_HOLD
    } jog_state_t;

    typedef enum logic [1:0] {
        STOP_FREE,
        STOP_DECEL,
        STOP_DCBRAKE
    } stop_kind_t;

endpackage

// ===== rtl/term_sync.sv
`timescale 1ns/1ns
module term_sync #(
    parameter int W = 8
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_nrst,
    input  wire logic [W-1:0] i_lvl,
    output logic      [W-1:0] o_lvl
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] lvl;
    } sync_t;

    sync_t st_q;
    sync_t st_d;

    always_comb begin
        st_d      = st_q;
        st_d.meta = i_lvl;
        st_d.lvl  = st_q.meta;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_lvl = st_q.lvl;

    chk_sync_two_stage: assert property (
        @(posedge i_ref_clk)
        i_nrst && $past(i_nrst) && $past(i_nrst, 2)
            |-> o_lvl == $past(i_lvl, 2))
        else $error("terminal level not delayed by two stages");

endmodule

// ===== rtl/term_decoder.sv
`timescale 1ns/1ns
`include "term_decoder_regs.svh"
module term_decoder
    import term_decoder_pkg::*;
#(
    parameter int N  = `TERM_COUNT,
    parameter int CW = `FUNC_CODE_W,
    parameter int FW = `FREQ_W
) (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_nrst,
    input  wire logic [N-1:0]         i_terminals,
    input  wire logic                 i_forward_run_input,
    input  wire logic                 i_reverse_run_input,
    input  wire logic [N*CW-1:0]      i_input_function_selectors,
    input  wire logic [1:0]           i_frequency_source_select,
    input  wire logic [1:0]           i_run_command_source_select,
    input  wire logic [7*FW-1:0]      i_step_speed_references,
    input  wire logic [FW-1:0]        i_panel_frequency_setting,
    input  wire logic [FW-1:0]        i_analog_frequency,
    input  wire logic [FW-1:0]        i_jog_frequency_setting,
    input  wire logic [FW-1:0]        i_starting_frequency,
    input  wire logic [2:0]           i_jog_stop_select,
    output logic      [FW-1:0]        o_freq_ref,
    output logic      [`STEP_W-1:0]   o_step_index,
    output logic                      o_run,
    output logic                      o_reverse,
    output logic                      o_jog_active,
    output logic                      o_ramp_bypass,
    output logic      [1:0]           o_stop_method,
    output logic                      o_two_step_ramp_input,
    output logic                      o_trip_clear_input,
    output logic                      o_three_wire_mode
);

    typedef struct packed {
        jog_state_t         state;
        stop_kind_t         stop;
        logic               run;
        logic               jog;
        logic               rev;
        logic               start_latch;
        logic               three_wire;
        logic               alt;
        logic               trip_prev;
        logic               trip_pulse;
        logic [`STEP_W-1:0] step;
        logic [FW-1:0]      freq;
        logic [FW-1:0]      jog_f;
    } ctl_t;

    ctl_t st_q;
    ctl_t st_d;

    logic [N-1:0]   term_lvl;
    logic           fw_lvl;
    logic           rv_lvl;

    term_sync #(
        .W (N + 2)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_lvl     ({i_reverse_run_input, i_forward_run_input, i_terminals}),
        .o_lvl     ({rv_lvl, fw_lvl, term_lvl})
    );

    // per-terminal decode of the function selector
    logic [N-1:0][`SPEED_BITS-1:0] spd_m;
    logic [N-1:0]                  jog_m;
    logic [N-1:0]                  alt_m;
    logic [N-1:0]                  trip_m;
    logic [N-1:0]                  sta_m;
    logic [N-1:0]                  stp_alloc_m;
    logic [N-1:0]                  stp_open_m;
    logic [N-1:0]                  dir_m;
    logic [FW-1:0]                 step_ref [`SPEED_BITS];

    for (genvar t = 0; t < N; t++) begin : g_term
        logic [CW-1:0] code;
        logic [CW-1:0] rel;
        logic          in_speed;
        assign code     = i_input_function_selectors[t*CW +: CW];
        assign rel      = code - `FUNC_SPEED_FIRST;
        assign in_speed = (code >= `FUNC_SPEED_FIRST) &&
                          (code <= `FUNC_SPEED_LAST);
        for (genvar f = 0; f < `SPEED_BITS; f++) begin : g_bit
            assign spd_m[t][f] = term_lvl[t] && in_speed &&
                                 (rel == CW'(f));
        end
        assign jog_m[t]       = term_lvl[t] && code == `FUNC_JOG;
        assign alt_m[t]       = term_lvl[t] &&
                                code == `FUNC_TWO_STEP;
        assign trip_m[t]      = term_lvl[t] &&
                                code == `FUNC_TRIP_CLEAR;
        assign sta_m[t]       = term_lvl[t] &&
                                code == `FUNC_3W_START;
        assign stp_alloc_m[t] = code == `FUNC_3W_STOP;
        assign stp_open_m[t]  = stp_alloc_m[t] && !term_lvl[t];
        assign dir_m[t]       = term_lvl[t] && code == `FUNC_3W_DIR;
    end

    for (genvar s = 0; s < `SPEED_BITS; s++) begin : g_ref
        assign step_ref[s] = i_step_speed_references[s*FW +: FW];
    end

    logic [`SPEED_BITS-1:0] spd_bits;
    logic                   jog_lvl;
    logic                   trip_lvl;
    logic                   sta_lvl;
    logic                   stp_alloc;
    logic                   stp_lvl;
    logic                   term_ok;
    logic                   jog_allowed;
    stop_kind_t             jog_kind;
    always_comb begin
        spd_bits = '0;
        for (int t = 0; t < N; t++) begin
            spd_bits = spd_bits | spd_m[t];
        end
    end
    assign jog_lvl   = |jog_m;
    assign trip_lvl  = |trip_m;
    assign sta_lvl   = |sta_m;
    assign stp_alloc = |stp_alloc_m;
    // several stop terminals act in series: any open one stops
    assign stp_lvl   = stp_alloc && !(|stp_open_m);
    // terminal run commands only count with the terminal block as source
    assign term_ok   = i_run_command_source_select == `RSRC_TERMINAL;
    assign jog_allowed = i_jog_stop_select >= `JSTOP_FREE_ON;
    always_comb begin
        case (i_jog_stop_select)
            `JSTOP_FREE_OFF,
            `JSTOP_FREE_ON:   jog_kind = STOP_FREE;
            `JSTOP_DECEL_OFF,
            `JSTOP_DECEL_ON:  jog_kind = STOP_DECEL;
            `JSTOP_DC_OFF,
            `JSTOP_DC_ON:     jog_kind = STOP_DCBRAKE;
            default:          jog_kind = STOP_FREE;
        endcase
    end

    logic run_cmd;
    logic rev_cmd;
    always_comb begin
        int n;
        n    = 0;
        st_d = st_q;

        // three-wire latch; a held start with stop open does not latch
        st_d.three_wire  = stp_alloc && term_ok;
        st_d.start_latch = stp_lvl && term_ok &&
                           (st_q.start_latch || sta_lvl);
        if (stp_alloc) begin
            run_cmd = st_d.start_latch;
            rev_cmd = |dir_m;
        end else begin
            run_cmd = term_ok && (fw_lvl || rv_lvl);
            rev_cmd = rv_lvl && !fw_lvl;
        end

        // lowest-numbered asserted bit wins
        st_d.step = '0;
        for (n = `SPEED_BITS - 1; n >= 0; n--) begin
            if (spd_bits[n]) begin
                st_d.step = `STEP_W'(n + 1);
            end
        end

        // jog frequency held within its legal span
        if (i_jog_frequency_setting > `JOG_FREQ_MAX) begin
            st_d.jog_f = `JOG_FREQ_MAX;
        end else if (i_jog_frequency_setting < i_starting_frequency) begin
            st_d.jog_f = i_starting_frequency;
        end else begin
            st_d.jog_f = i_jog_frequency_setting;
        end

        case (st_q.state)
            ST_IDLE: begin
                if (run_cmd && jog_lvl) begin
                    st_d.state = ST_JOG;
                end else if (run_cmd) begin
                    st_d.state = ST_RUN;
                    st_d.stop  = STOP_DECEL;
                end
            end
            ST_RUN: begin
                if (!run_cmd) begin
                    st_d.state = ST_IDLE;
                    st_d.stop  = STOP_DECEL;
                end else if (jog_lvl && jog_allowed) begin
                    st_d.state = ST_JOG;
                end
            end
            ST_JOG: begin
                if (!run_cmd) begin
                    st_d.state = ST_IDLE;
                    st_d.stop  = jog_kind;
                end else if (!jog_lvl) begin
                    // no restart until the run command is dropped
                    st_d.state = ST_HOLD;
                    st_d.stop  = jog_allowed ? STOP_FREE : jog_kind;
                end
            end
            ST_HOLD: begin
                if (!run_cmd) begin
                    st_d.state = ST_IDLE;
                end
            end
            default: begin
                st_d.state = ST_IDLE;
            end
        endcase
        st_d.run = st_d.state == ST_RUN || st_d.state == ST_JOG;
        st_d.jog = st_d.state == ST_JOG;
        st_d.rev = st_d.run ? rev_cmd : st_q.rev;
        if (st_d.jog) begin
            st_d.freq = st_d.jog_f;
        end else if (st_d.step != '0) begin
            st_d.freq = step_ref[st_d.step - `STEP_W'(1)];
        end else if (i_frequency_source_select == `FSRC_PANEL) begin
            st_d.freq = i_panel_frequency_setting;
        end else if (i_frequency_source_select == `FSRC_ANALOG) begin
            st_d.freq = i_analog_frequency;
        end else begin
            st_d.freq = '0;
        end

        st_d.alt        = |alt_m;
        st_d.trip_prev  = trip_lvl;
        st_d.trip_pulse = trip_lvl && !st_q.trip_prev;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            st_q       <= '0;
            st_q.state <= ST_IDLE;
            st_q.stop  <= STOP_DECEL;
            st_q.jog_f <= `JOG_FREQ_DEFAULT;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_freq_ref            = st_q.freq;
    assign o_step_index          = st_q.step;
    assign o_run                 = st_q.run;
    assign o_reverse             = st_q.rev;
    assign o_jog_active          = st_q.jog;
    assign o_ramp_bypass         = st_q.jog;
    assign o_stop_method         = st_q.stop;
    assign o_two_step_ramp_input = st_q.alt;
    assign o_trip_clear_input    = st_q.trip_pulse;
    assign o_three_wire_mode     = st_q.three_wire;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_stop_opened;
        stp_alloc && !stp_lvl;
    endsequence
    // a jog in flight may end in hold, which rightly drops the run
    sequence s_start_press;
        stp_lvl && sta_lvl && term_ok && !jog_lvl &&
            (st_q.state == ST_IDLE || st_q.state == ST_RUN);
    endsequence
    sequence s_start_released;
        stp_lvl && !sta_lvl && term_ok && !jog_lvl;
    endsequence

    chk_step_lowest_bit: assert property (
        spd_bits[0] |=> o_step_index == 3'h1)
        else $error("speed bit one did not take priority");
    chk_higher_ignored: assert property (
        spd_bits[1] && !spd_bits[0] && !o_jog_active ##0 !st_d.jog
            |=> o_step_index == 3'h2 && o_freq_ref == $past(step_ref[1]))
        else $error("higher speed bit changed the step");
    chk_step_zero_src: assert property (
        spd_bits == '0 && !st_d.jog &&
            i_frequency_source_select == `FSRC_PANEL
            |=> o_step_index == '0 &&
                o_freq_ref == $past(i_panel_frequency_setting))
        else $error("step zero not taken from panel");
    chk_jog_no_ramp: assert property (
        o_jog_active |-> o_ramp_bypass && o_freq_ref == st_q.jog_f &&
            o_freq_ref <= `JOG_FREQ_MAX)
        else $error("jog frequency not applied directly");
    chk_jog_refused: assert property (
        st_q.state == ST_RUN && !jog_allowed && run_cmd
            |=> !o_jog_active)
        else $error("jog entered after run in refusing mode");
    chk_jog_allowed: assert property (
        st_q.state == ST_RUN && jog_allowed && run_cmd && jog_lvl
            |=> o_jog_active && o_run)
        else $error("jog not entered while running");
    chk_jog_coast: assert property (
        st_q.state == ST_JOG && jog_allowed && run_cmd && !jog_lvl
            |=> !o_run && o_stop_method == STOP_FREE)
        else $error("jog release did not free-run stop");
    chk_stop_cancels: assert property (
        s_stop_opened |=> !st_q.start_latch && !o_run)
        else $error("three-wire stop did not stop the motor");
    chk_start_holds: assert property (
        s_start_press ##1 s_start_released |=> o_run)
        else $error("run lost on start release");
    chk_fw_ignored: assert property (
        stp_alloc && !st_q.start_latch && !sta_lvl && fw_lvl
            |=> !o_run)
        else $error("forward run honoured with stop allocated");
    chk_trip_pulse: assert property (
        $rose(trip_lvl) |=> o_trip_clear_input ##1 !o_trip_clear_input)
        else $error("trip clear not a single pulse");
endmodule

// ===== verification/term_switches.sv
`timescale 1ns/1ns
module term_switches (
    input  wire logic       i_ref_clk,
    input  wire logic [7:0] i_contacts,
    input  wire logic       i_fw_contact,
    input  wire logic       i_rv_contact,
    output logic      [7:0] o_terminals,
    output logic            o_forward_run_input,
    output logic            o_reverse_run_input
);
    // contacts reach the terminals one clock late, as through a relay path
    always_ff @(posedge i_ref_clk) begin
        o_terminals         <= i_contacts;
        // run contacts take the same one-clock delay as the terminals
        o_forward_run_input <= i_fw_contact;
        o_reverse_run_input <= i_rv_contact;
    end
endmodule

// ===== verification/tb_input_terminal_function_decoder.sv
`timescale 1ns/1ns
module tb_input_terminal_function_decoder;
    import term_decoder_pkg::*;
    logic        clk;
    logic        nrst;
    logic [7:0]  sw;
    logic        fw;
    logic        rv;
    logic [7:0]  term;
    logic        fw_t;
    logic        rv_t;
    logic [47:0] sel;
    logic [1:0]  fsrc;
    logic [1:0]  rsrc;
    logic [111:0] refs;
    logic [15:0] jog_f;
    logic [2:0]  jss;
    logic [15:0] freq;
    logic [2:0]  step;
    logic        run;
    logic        rev;
    logic        jog;
    logic        byp;
    logic [1:0]  stop_m;
    logic        two;
    logic        trip;
    logic        tw;
    int          err_count;
    int          comparisons;

    term_switches sw_model (
        .i_ref_clk(clk), .i_contacts(sw), .i_fw_contact(fw),
        .i_rv_contact(rv), .o_terminals(term),
        .o_forward_run_input(fw_t), .o_reverse_run_input(rv_t));

    term_decoder dut (
        .i_ref_clk(clk), .i_nrst(nrst), .i_terminals(term),
        .i_forward_run_input(fw_t), .i_reverse_run_input(rv_t),
        .i_input_function_selectors(sel),
        .i_frequency_source_select(fsrc),
        .i_run_command_source_select(rsrc),
        .i_step_speed_references(refs),
        .i_panel_frequency_setting(16'h1234),
        .i_analog_frequency(16'h0ABC),
        .i_jog_frequency_setting(jog_f),
        .i_starting_frequency(16'h0032),
        .i_jog_stop_select(jss), .o_freq_ref(freq), .o_step_index(step),
        .o_run(run), .o_reverse(rev), .o_jog_active(jog),
        .o_ramp_bypass(byp), .o_stop_method(stop_m),
        .o_two_step_ramp_input(two), .o_trip_clear_input(trip),
        .o_three_wire_mode(tw));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    // sync plus state flop plus switch model: six edges is settled
    task automatic put(input logic [7:0] c, input logic f, input logic r);
        @(posedge clk);
        sw <= c;
        fw <= f;
        rv <= r;
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic cfg(input int t, input logic [5:0] code);
        @(posedge clk);
        sel[t*6+:6] <= code;
    endtask

    task automatic test_speed();
        @(posedge clk);
        fsrc <= 2'h2;
        put(8'h00, 1'b0, 1'b0);
        chk(freq, 16'h1234);
        chk(16'(step), 16'h0000);
        @(posedge clk);
        fsrc <= 2'h1;
        put(8'h00, 1'b0, 1'b0);
        chk(freq, 16'h0ABC);
        for (int n = 0; n < 7; n++) begin
            cfg(0, 6'(32 + n));
            put(8'h01, 1'b0, 1'b0);
            chk(16'(step), 16'(n + 1));
            chk(freq, 16'(16'h0101 + n));
        end
        cfg(0, 6'h26);
        cfg(1, 6'h21);
        cfg(2, 6'h20);
        put(8'h07, 1'b0, 1'b0);
        chk(16'(step), 16'h0001);
        put(8'h03, 1'b0, 1'b0);
        chk(16'(step), 16'h0002);
        chk(freq, 16'h0102);
        put(8'h01, 1'b0, 1'b0);
        chk(16'(step), 16'h0007);
        put(8'h00, 1'b0, 1'b0);
        $display("test speed done");
    endtask

    task automatic test_jog();
        for (int m = 0; m < 6; m++) begin
            @(posedge clk);
            jss <= 3'(m);
            put(8'h08, 1'b0, 1'b0);
            put(8'h08, 1'b1, 1'b0);
            chk({13'h0, run, jog, byp}, 16'h0007);
            chk(freq, 16'h0258);
            put(8'h08, 1'b0, 1'b0);
            chk({14'h0, run, jog}, 16'h0000);
            chk(16'(stop_m), 16'(m % 3));
            put(8'h00, 1'b0, 1'b0);
        end
        @(posedge clk);
        jss <= 3'h0;
        put(8'h00, 1'b1, 1'b0);
        put(8'h08, 1'b1, 1'b0);
        chk({14'h0, run, jog}, 16'h0002);
        put(8'h00, 1'b0, 1'b0);
        @(posedge clk);
        jss <= 3'h4;
        jog_f <= 16'h0400;
        put(8'h00, 1'b1, 1'b0);
        put(8'h08, 1'b1, 1'b0);
        chk({14'h0, run, jog}, 16'h0003);
        chk(freq, 16'h03E7);
        put(8'h00, 1'b1, 1'b0);
        chk({14'h0, run, jog}, 16'h0000);
        chk(16'(stop_m), 16'h0000);
        put(8'h00, 1'b0, 1'b0);
        @(posedge clk);
        jog_f <= 16'h0010;
        put(8'h08, 1'b1, 1'b0);
        chk(freq, 16'h0032);
        put(8'h00, 1'b0, 1'b0);
        @(posedge clk);
        jog_f <= 16'h0258;
        $display("test jog done");
    endtask

    task automatic test_misc();
        int cnt;
        cnt = 0;
        cfg(4, 6'h09);
        cfg(5, 6'h12);
        put(8'h10, 1'b0, 1'b0);
        chk(16'(two), 16'h0001);
        @(posedge clk);
        sw <= 8'h30;
        repeat (8) begin
            @(posedge clk);
            #1;
            cnt += int'(trip === 1'b1);
        end
        chk(16'(cnt), 16'h0001);
        chk(16'(two), 16'h0001);
        put(8'h00, 1'b0, 1'b0);
        chk(16'(two), 16'h0000);
        $display("test two-step and trip done");
    endtask

    task automatic test_3wire();
        cfg(4, 6'h15);
        cfg(6, 6'h14);
        cfg(7, 6'h16);
        put(8'h10, 1'b1, 1'b0);
        chk({14'h0, tw, run}, 16'h0002);
        put(8'h50, 1'b0, 1'b0);
        chk({14'h0, run, rev}, 16'h0002);
        put(8'h10, 1'b0, 1'b0);
        chk(16'(run), 16'h0001);
        put(8'h90, 1'b0, 1'b0);
        chk({14'h0, run, rev}, 16'h0003);
        put(8'h80, 1'b0, 1'b0);
        chk(16'(run), 16'h0000);
        put(8'hC0, 1'b0, 1'b0);
        chk(16'(run), 16'h0000);
        put(8'h10, 1'b0, 1'b0);
        chk(16'(run), 16'h0000);
        @(posedge clk);
        rsrc <= 2'h2;
        put(8'h50, 1'b0, 1'b0);
        chk({14'h0, tw, run}, 16'h0000);
        @(posedge clk);
        rsrc <= 2'h1;
        put(8'h00, 1'b0, 1'b0);
        $display("test three-wire done");
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #(100 * 4000);
        err_count++;
        close_out();
    end

    initial begin
        err_count = 0;
        comparisons = 0;
        nrst = 1'b0;
        sw = 8'h00;
        fw = 1'b0;
        rv = 1'b0;
        sel = {6'h00, 6'h00, 6'h00, 6'h00, 6'h06, 6'h00, 6'h00, 6'h00};
        fsrc = 2'h2;
        rsrc = 2'h1;
        jog_f = 16'h0258;
        jss = 3'h0;
        for (int n = 0; n < 7; n++) begin
            refs[n*16+:16] = 16'(16'h0101 + n);
        end
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        test_speed();
        test_jog();
        test_misc();
        test_3wire();
        close_out();
    end
endmodule
